// ===== msc_regs.vh
// Constants for the multi-protocol serial channel
`ifndef MSC_REGS_VH
`define MSC_REGS_VH
`define MSC_MODE_SPI3 2'h0
`define MSC_MODE_SPI4 2'h1
`define MSC_MODE_UART 2'h2
`define MSC_MODE_IIC 2'h3
`define MSC_PAR_NONE 2'h0
`define MSC_PAR_EVEN 2'h1
`define MSC_PAR_ODD 2'h2
`define MSC_SPI_MIN_LAST 4'h6
`define MSC_IIC_LAST 4'h8
`define MSC_ULEN7_LAST 4'h6
`define MSC_ULEN8_LAST 4'h7
`define MSC_ULEN9_LAST 4'h8
`define MSC_ULEN16_LAST 4'hf
`define MSC_ULEN7 2'h0
`define MSC_ULEN8 2'h1
`define MSC_ULEN9 2'h2
`define MSC_ULEN16 2'h3
`define MSC_PRE_W 15
`define MSC_DIV_W 8
`define MSC_RST_SDO 1'b1
`endif

// ===== msc_divider.v
// Prescaler plus channel counter giving a one-cycle half-bit tick
`timescale 1ns/1ps
`include "msc_regs.vh"
module msc_divider (
  input wire sys_clk,
  input wire rst,
  input wire clr,
  input wire [3:0] prescale_sel,
  input wire [`MSC_DIV_W-1:0] divisor,
  output reg tick
);
  reg [`MSC_PRE_W-1:0] pre_reg;
  reg [`MSC_DIV_W-1:0] cnt_reg;
  // Shift wraps to zero at 15, so the mask still comes out all ones
  wire [`MSC_PRE_W-1:0] pre_mask =
    ({{(`MSC_PRE_W-1){1'b0}}, 1'b1} << prescale_sel) -
    {{(`MSC_PRE_W-1){1'b0}}, 1'b1};
  wire pre_en = (pre_reg == pre_mask);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_reg <= {`MSC_PRE_W{1'b0}};
      cnt_reg <= {`MSC_DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (clr) begin
      pre_reg <= {`MSC_PRE_W{1'b0}};
      cnt_reg <= {`MSC_DIV_W{1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      pre_reg <= pre_en ? {`MSC_PRE_W{1'b0}} : pre_reg + 1'b1;
      if (pre_en) begin
        if (cnt_reg == divisor) begin
          cnt_reg <= {`MSC_DIV_W{1'b0}};
          tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule

// ===== msc_channel.v
// One serial channel: clocked serial, four-wire slave, async, two-wire
`timescale 1ns/1ps
`include "msc_regs.vh"
module msc_channel (
  input wire sys_clk,
  input wire rst,
  input wire [1:0] mode,
  input wire master_en,
  input wire [3:0] frame_last,
  input wire lsb_first,
  input wire cpha,
  input wire cpol,
  input wire data_inv,
  input wire uart_inv,
  input wire [1:0] parity_mode,
  input wire stop_two,
  input wire [1:0] uart_len,
  input wire uart_rx_role,
  input wire ack_out_en,
  input wire [3:0] prescale_sel,
  input wire [7:0] divisor,
  input wire scl_force_low,
  input wire sda_force_low,
  input wire [15:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  output reg [15:0] rx_data,
  output reg rx_valid,
  input wire rx_taken,
  input wire flag_clear,
  output reg xfer_done_irq,
  output reg buf_empty_irq,
  output reg err_irq,
  output reg overrun_flag,
  output reg framing_flag,
  output reg parity_flag,
  output reg nack_flag,
  output wire busy,
  input wire sck_in,
  output wire sck_out,
  output wire sck_oe,
  input wire slave_select_input_n,
  input wire sdata_in,
  output wire sdata_out,
  output wire sdata_oe
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_FIN = 3'h5;

  reg [2:0] state_reg;
  reg [3:0] cnt_reg;
  reg half_reg;
  reg sck_reg;
  reg sdo_reg;
  reg par_reg;
  reg sck_prev_reg;
  reg tx_full_reg;
  reg [15:0] tx_buf_reg;
  reg [15:0] tx_sh_reg;
  reg [15:0] rx_sh_reg;
  reg [3:0] last_bit;
  wire tick;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode and bit indexing

  wire is_uart = (mode == `MSC_MODE_UART);
  wire is_iic = (mode == `MSC_MODE_IIC);
  wire is_spi4 = (mode == `MSC_MODE_SPI4);
  wire spi_master = (mode == `MSC_MODE_SPI3) & master_en;
  // Two-wire mode only ever drives the clock itself
  wire clk_master = spi_master | is_iic;
  wire eff_cpha = is_iic | cpha;
  wire eff_cpol = is_iic | cpol;
  wire eff_lsb = ~is_iic & lsb_first;
  wire uart_tx = is_uart & ~uart_rx_role;
  wire uart_rx = is_uart & uart_rx_role;
  wire line_inv = is_uart ? uart_inv : (is_spi4 & data_inv);
  wire din = sdata_in ^ line_inv;
  wire sel_ok = ~is_spi4 | ~slave_select_input_n;

  always @* begin
    if (is_iic) begin
      last_bit = `MSC_IIC_LAST;
    end else if (is_uart) begin
      case (uart_len)
        `MSC_ULEN7: last_bit = `MSC_ULEN7_LAST;
        `MSC_ULEN8: last_bit = `MSC_ULEN8_LAST;
        `MSC_ULEN9: last_bit = `MSC_ULEN9_LAST;
        default: last_bit = `MSC_ULEN16_LAST;
      endcase
    end else if (frame_last < `MSC_SPI_MIN_LAST) begin
      last_bit = `MSC_SPI_MIN_LAST;
    end else begin
      last_bit = frame_last;
    end
  end

  wire [3:0] cur_idx = eff_lsb ? cnt_reg : last_bit - cnt_reg;
  wire [3:0] nxt_idx = eff_lsb ? cnt_reg + 4'h1 : last_bit - cnt_reg - 4'h1;
  wire [3:0] first_idx = eff_lsb ? 4'h0 : last_bit;
  wire tx_bit = tx_sh_reg[cur_idx];
  wire tx_nxt = tx_sh_reg[nxt_idx];
  // Ninth bit of a two-wire frame is our acknowledge, low when enabled
  wire [15:0] load_word = is_iic ?
    {7'h00, tx_buf_reg[7:0], ~ack_out_en} : tx_buf_reg;
  wire [15:0] rx_fill = (rx_sh_reg & ~(16'h0001 << cur_idx)) |
    ({15'h0000, din} << cur_idx);

  ////////////////////////////////////////////////////////////////////////
  // Event generation

  msc_divider u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(state_reg == ST_IDLE),
    .prescale_sel(prescale_sel),
    .divisor(divisor),
    .tick(tick)
  );

  // Half-bit ticks toggle the clock, so it is never above half rate
  wire m_lead = clk_master & tick & ~half_reg;
  wire m_trail = clk_master & tick & half_reg;
  // Slave edges use the pin as-is; a slow enough clock needs no filter
  wire s_edge = ~clk_master & ~is_uart & (sck_in != sck_prev_reg);
  wire s_lead = s_edge & (sck_in != eff_cpol) & sel_ok;
  wire s_trail = s_edge & (sck_in == eff_cpol) & sel_ok;
  wire lead_ev = (state_reg == ST_DATA) & (m_lead | s_lead);
  wire trail_ev = (state_reg == ST_DATA) & (m_trail | s_trail);
  wire sample_ev = eff_cpha ? trail_ev : lead_ev;
  wire shift_ev = eff_cpha ? lead_ev : trail_ev;
  wire uevt = is_uart & tick & half_reg;

  ////////////////////////////////////////////////////////////////////////
  // Word completion

  task finish_word;
    input [15:0] w;
    begin
      xfer_done_irq <= 1'b1;
      if (is_iic) begin
        rx_data <= {8'h00, w[8:1]};
      end else begin
        rx_data <= w;
      end
      rx_valid <= 1'b1;
      if (rx_valid & ~rx_taken) begin
        overrun_flag <= 1'b1;
        err_irq <= 1'b1;
      end
      if (is_iic & ~ack_out_en & w[0]) begin
        nack_flag <= 1'b1;
        err_irq <= 1'b1;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequencer

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      half_reg <= 1'b0;
      sck_reg <= 1'b0;
      sdo_reg <= `MSC_RST_SDO;
      par_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      tx_full_reg <= 1'b0;
      tx_buf_reg <= 16'h0000;
      tx_sh_reg <= 16'h0000;
      rx_sh_reg <= 16'h0000;
      rx_data <= 16'h0000;
      rx_valid <= 1'b0;
      xfer_done_irq <= 1'b0;
      buf_empty_irq <= 1'b0;
      err_irq <= 1'b0;
      overrun_flag <= 1'b0;
      framing_flag <= 1'b0;
      parity_flag <= 1'b0;
      nack_flag <= 1'b0;
    end else begin
      xfer_done_irq <= 1'b0;
      buf_empty_irq <= 1'b0;
      err_irq <= 1'b0;
      sck_prev_reg <= sck_in;
      if (tx_valid & ~tx_full_reg) begin
        tx_buf_reg <= tx_data;
        tx_full_reg <= 1'b1;
      end
      if (rx_taken) begin
        rx_valid <= 1'b0;
      end
      // Clears come first so a same-cycle event below wins
      if (flag_clear) begin
        overrun_flag <= 1'b0;
        framing_flag <= 1'b0;
        parity_flag <= 1'b0;
        nack_flag <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          half_reg <= 1'b0;
          cnt_reg <= 4'h0;
          rx_sh_reg <= 16'h0000;
          par_reg <= (parity_mode == `MSC_PAR_ODD);
          if (is_iic) begin
            sck_reg <= ~scl_force_low;
            sdo_reg <= ~sda_force_low;
          end else begin
            sck_reg <= eff_cpol;
            sdo_reg <= 1'b1;
          end
          if (uart_rx) begin
            if (~din) begin
              half_reg <= 1'b1;
              state_reg <= ST_START;
            end
          end else if (tx_full_reg | (~is_uart & ~clk_master)) begin
            // A slave stays armed and resends stale data when unfed
            tx_sh_reg <= load_word;
            // Keeps a same-cycle write when a slave rearms with stale data
            tx_full_reg <= ~tx_full_reg & tx_valid;
            buf_empty_irq <= tx_full_reg;
            if (is_uart) begin
              sdo_reg <= 1'b0;
              state_reg <= ST_START;
            end else begin
              sdo_reg <= load_word[first_idx];
              state_reg <= ST_DATA;
            end
          end
        end
        ST_START: begin
          if (tick) begin
            half_reg <= ~half_reg;
          end
          if (uevt) begin
            if (uart_rx & din) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_DATA;
              if (uart_tx) begin
                sdo_reg <= tx_bit;
                par_reg <= par_reg ^ tx_bit;
              end
            end
          end
        end
        ST_DATA: begin
          if (is_uart) begin
            if (tick) begin
              half_reg <= ~half_reg;
            end
            if (uevt) begin
              if (uart_rx) begin
                rx_sh_reg <= rx_fill;
                par_reg <= par_reg ^ din;
              end
              if (cnt_reg == last_bit) begin
                cnt_reg <= 4'h0;
                if (parity_mode != `MSC_PAR_NONE) begin
                  state_reg <= ST_PAR;
                  sdo_reg <= uart_tx ? par_reg : 1'b1;
                end else begin
                  state_reg <= ST_STOP;
                  sdo_reg <= 1'b1;
                end
              end else begin
                cnt_reg <= cnt_reg + 4'h1;
                if (uart_tx) begin
                  sdo_reg <= tx_nxt;
                  par_reg <= par_reg ^ tx_nxt;
                end
              end
            end
          end else if (is_spi4 & slave_select_input_n) begin
            cnt_reg <= 4'h0;
            rx_sh_reg <= 16'h0000;
            sdo_reg <= tx_sh_reg[first_idx];
          end else begin
            // No arbitration or stretch check: the clock pin is not read
            if (clk_master & tick) begin
              half_reg <= ~half_reg;
              sck_reg <= ~sck_reg;
            end
            if (shift_ev) begin
              sdo_reg <= tx_bit;
            end
            if (sample_ev) begin
              rx_sh_reg <= rx_fill;
              if (cnt_reg == last_bit) begin
                finish_word(rx_fill);
                state_reg <= (clk_master & ~eff_cpha) ? ST_FIN : ST_IDLE;
              end else begin
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
        end
        ST_PAR: begin
          if (tick) begin
            half_reg <= ~half_reg;
          end
          if (uevt) begin
            if (uart_rx & (din != par_reg)) begin
              parity_flag <= 1'b1;
              err_irq <= 1'b1;
            end
            sdo_reg <= 1'b1;
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick) begin
            half_reg <= ~half_reg;
          end
          if (uevt) begin
            if (uart_rx) begin
              if (~din) begin
                framing_flag <= 1'b1;
                err_irq <= 1'b1;
              end
              finish_word(rx_sh_reg);
              state_reg <= ST_IDLE;
            end else if (stop_two & (cnt_reg == 4'h0)) begin
              cnt_reg <= 4'h1;
            end else begin
              xfer_done_irq <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_FIN: begin
          if (tick) begin
            sck_reg <= eff_cpol;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins

  assign tx_ready = ~tx_full_reg;
  assign busy = (state_reg != ST_IDLE);
  // Two-wire lines are open drain: only ever pulled low
  assign sck_out = is_iic ? 1'b0 : sck_reg;
  assign sck_oe = is_iic ? ~sck_reg : spi_master;
  assign sdata_out = is_iic ? 1'b0 : (sdo_reg ^ line_inv);
  assign sdata_oe = is_iic ? ~sdo_reg :
    (is_uart ? uart_tx : sel_ok);
endmodule

// ===== msc_channel_props.sv
// Port-level concurrent checks for the serial channel
`timescale 1ns/1ps
module msc_chk (
  input wire sys_clk,
  input wire rst,
  input wire [1:0] mode,
  input wire master_en,
  input wire [3:0] prescale_sel,
  input wire [7:0] divisor,
  input wire slave_select_input_n,
  input wire tx_valid,
  input wire tx_ready,
  input wire rx_valid,
  input wire xfer_done_irq,
  input wire buf_empty_irq,
  input wire err_irq,
  input wire overrun_flag,
  input wire parity_flag,
  input wire busy,
  input wire sck_out,
  input wire sck_oe,
  input wire sdata_out,
  input wire sdata_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Buffer take, then a bounded wait for the move into the shifter
  sequence take_s;
    tx_valid && tx_ready;
  endsequence
  sequence move_s;
    !tx_ready ##[1:200] (buf_empty_irq && tx_ready);
  endsequence
  done_pulse_a: assert property (xfer_done_irq |=> !xfer_done_irq)
    else $error("transfer done pulse held too long");
  done_word_a: assert property (xfer_done_irq |-> rx_valid)
    else $error("received word not valid at done");
  buf_move_a: assert property (take_s |=> move_s)
    else $error("buffer word not moved or no empty pulse");
  empty_busy_a: assert property (buf_empty_irq |-> busy ##1 busy)
    else $error("empty pulse without a running frame");
  sel_idle_a: assert property ((mode == 2'h1 && $past(mode) == 2'h1 &&
    slave_select_input_n && $past(slave_select_input_n)) |-> !sdata_oe)
    else $error("data driven while not selected");
  // Fixed divider setting only: a general gap check needs a counter
  clk_gap_a: assert property ((mode == 2'h0 && master_en &&
    prescale_sel == 4'h1 && divisor == 8'h0 && $changed(sck_out))
    |=> $stable(sck_out))
    else $error("clock edge earlier than the divider allows");
  open_drain_a: assert property ((mode == 2'h3 && $past(mode) == 2'h3)
    |-> !(sck_oe && sck_out) && !(sdata_oe && sdata_out))
    else $error("two-wire line driven high");
  parity_err_a: assert property ($rose(parity_flag) |-> err_irq)
    else $error("parity flag without error pulse");
  overrun_err_a: assert property ($rose(overrun_flag) |-> err_irq)
    else $error("overrun flag without error pulse");
endmodule
bind msc_channel msc_chk i_msc_chk (.sys_clk, .rst, .mode, .master_en,
  .prescale_sel, .divisor, .slave_select_input_n, .tx_valid, .tx_ready,
  .rx_valid, .xfer_done_irq, .buf_empty_irq, .err_irq, .overrun_flag,
  .parity_flag, .busy, .sck_out, .sck_oe, .sdata_out, .sdata_oe);

// ===== msc_peer.sv
// Far-side peer: clocked shift slave and async line driver
`timescale 1ns/1ps
module msc_peer (
  input wire sys_clk,
  input wire scl,
  input wire mosi,
  output wire sdi,
  output wire sck
);
  reg [15:0] out_reg = 16'hffff;
  // Starts all ones so a silent data line still shows up
  reg [15:0] cap_reg = 16'hffff;
  reg line_reg = 1'b1;
  reg uon_reg = 1'b0;
  reg sck_reg = 1'b0;
  assign sdi = uon_reg ? line_reg : out_reg[15];
  assign sck = sck_reg;
  ////////////////////////////////////////////////////////////
  // Spent bits come back inverted so a stale level never passes
  always @(posedge scl) cap_reg <= {cap_reg[14:0], mosi};
  always @(negedge scl) out_reg <= {out_reg[14:0], ~out_reg[15]};
  task load(input [15:0] v);
    begin
      uon_reg = 1'b0;
      out_reg = v;
    end
  endtask
  // Six system clocks a bit keeps the slave clock at one sixth
  task clk(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        repeat (3) @(negedge sys_clk);
        sck_reg = 1'b1;
        repeat (3) @(negedge sys_clk);
        sck_reg = 1'b0;
      end
    end
  endtask
  // Samples each bit of a sent frame near its middle
  task urx(output [10:0] f);
    integer k;
    begin
      @(negedge mosi);
      repeat (4) @(negedge sys_clk);
      for (k = 0; k < 11; k = k + 1) begin
        f[k] = mosi;
        repeat (4) @(negedge sys_clk);
      end
    end
  endtask
  // Start, eight bits low first, even parity unless bad, one stop
  task uart(input [7:0] b, input bad);
    reg [10:0] f;
    integer i;
    begin
      f = {1'b1, ^b ^ bad, b, 1'b0};
      uon_reg = 1'b1;
      for (i = 0; i < 11; i = i + 1) begin
        line_reg = f[i];
        repeat (4) @(negedge sys_clk);
      end
    end
  endtask
endmodule

// ===== msc_channel_tb.sv
// Self-checking bench for the multi-protocol serial channel
`timescale 1ns/1ps
`define CHK(n, g, x) begin checks++; if ((g) !== (x)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, x, g); end end
module msc_channel_tb;
  reg sys_clk = 1'b0, rst = 1'b1, master_en = 1'b1, lsb_first = 1'b0;
  reg cpha = 1'b0, cpol = 1'b0, uart_rx_role = 1'b0, tx_valid = 1'b0;
  reg scl_force_low = 1'b0, sda_force_low = 1'b0, rx_taken = 1'b0;
  reg flag_clear = 1'b0, slave_select_input_n = 1'b1, ack_out_en = 1'b0;
  reg [1:0] mode = 2'h0, parity_mode = 2'h0, uart_len = 2'h0;
  reg [3:0] frame_last = 4'hf, prescale_sel = 4'h1;
  reg [7:0] divisor = 8'h0;
  reg [15:0] tx_data = 16'h0;
  reg [31:0] seed = 32'hc8c7, e;
  reg [31:0] q[$];
  reg [10:0] uf;
  integer error_cnt = 0, checks = 0, cyc = 0, i;
  wire [15:0] rx_data;
  wire tx_ready, rx_valid, xfer_done_irq, buf_empty_irq, err_irq, busy;
  wire overrun_flag, framing_flag, parity_flag, nack_flag;
  wire sck_out, sck_oe, sdata_out, sdata_oe, pdi, psck;
  // Both open-drain lines float high when nobody pulls them
  wire scl = (mode == 2'h1) ? psck : (sck_oe ? sck_out : 1'b1);
  wire sda = (sdata_oe ? sdata_out : 1'b1) & (mode == 2'h3 ? pdi : 1'b1);
  wire sdata_in = (mode == 2'h3) ? sda : pdi;
  // Undriven data shows the inverse so a late enable is caught
  wire mosi = (mode == 2'h3) ? sda : (sdata_oe ? sdata_out : ~sdata_out);
  msc_channel i_msc_channel (.sys_clk, .rst, .mode, .master_en, .frame_last,
    .lsb_first, .cpha, .cpol, .data_inv(1'b0), .uart_inv(1'b0), .parity_mode,
    .stop_two(1'b0), .uart_len, .uart_rx_role, .ack_out_en,
    .prescale_sel, .divisor, .scl_force_low, .sda_force_low, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_taken, .flag_clear,
    .xfer_done_irq, .buf_empty_irq, .err_irq, .overrun_flag, .framing_flag,
    .parity_flag, .nack_flag, .busy, .sck_in(scl), .sck_out, .sck_oe,
    .slave_select_input_n, .sdata_in, .sdata_out, .sdata_oe);
  msc_peer i_msc_peer (.sys_clk, .scl, .mosi, .sdi(pdi), .sck(psck));
  ////////////////////////////////////////////////////////////
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  always @(negedge sys_clk) if (xfer_done_irq === 1'b1 && q.size() != 0) begin
    e = q.pop_front();
    `CHK("rx_data", rx_data & e[31:16], e[15:0])
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task wt(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task send(input [15:0] w, input [31:0] x);
    integer n;
    begin
      n = 0;
      while (tx_ready !== 1'b1 && n < 300) begin
        wt(1);
        n++;
      end
      q.push_back(x);
      tx_data = w;
      tx_valid = 1'b1;
      wt(1);
      tx_valid = 1'b0;
      n = 0;
      while (q.size() != 0 && n < 300) begin
        wt(1);
        n++;
      end
      wt(2);
    end
  endtask
  task spi(input p);
    reg [15:0] w, r, m;
    begin
      mode = 2'h0;
      master_en = 1'b1;
      cpol = p;
      cpha = p;
      frame_last = p ? 4'he : 4'hf;
      m = p ? 16'h7fff : 16'hffff;
      seed = xs(seed);
      w = seed[15:0];
      r = seed[31:16] & m;
      wt(3);
      i_msc_peer.load(r);
      send(w, {m, r});
      `CHK("peer_word", i_msc_peer.cap_reg & m, w & m)
    end
  endtask
  task ur(input bad);
    begin
      seed = xs(seed);
      if (!bad)
        q.push_back({16'h00ff, 8'h0, seed[7:0]});
      i_msc_peer.uart(seed[7:0], bad);
      wt(3);
    end
  endtask
  task take;
    begin
      rx_taken = 1'b1;
      wt(1);
      rx_taken = 1'b0;
    end
  endtask
  task iic(input nak, input ack);
    begin
      ack_out_en = ack;
      sda_force_low = 1'b1;
      wt(2);
      scl_force_low = 1'b1;
      wt(2);
      sda_force_low = 1'b0;
      scl_force_low = 1'b0;
      wt(3);
      seed = xs(seed);
      i_msc_peer.load({1'b1, 8'hff, nak, 6'h3f});
      send({8'h0, seed[7:0]}, {16'h00ff, 8'h0, seed[7:0]});
      `CHK("peer_byte", i_msc_peer.cap_reg[8:1], seed[7:0])
      `CHK("nack_flag", nack_flag, nak & ~ack)
      `CHK("ack_bit", i_msc_peer.cap_reg[0], nak & ~ack)
    end
  endtask
  task report_and_stop;
    begin
      `CHK("pending", q.size(), 0)
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    wt(2);
    mode = 2'h1;
    master_en = 1'b0;
    wt(3);
    `CHK("sdata_oe", sdata_oe, 1'b0)
    seed = xs(seed);
    i_msc_peer.load(seed[15:0]);
    q.push_back({16'hffff, seed[15:0]});
    slave_select_input_n = 1'b0;
    i_msc_peer.clk(16);
    wt(3);
    slave_select_input_n = 1'b1;
    `CHK("peer_word", i_msc_peer.cap_reg, 16'h0000)
    `CHK("pending", q.size(), 0)
    rst = 1'b1;
    mode = 2'h0;
    master_en = 1'b1;
    wt(2);
    rst = 1'b0;
    wt(2);
    $display("test select done");
    for (i = 0; i < 4; i = i + 1)
      spi(i[0]);
    $display("test clocked done");
    i_msc_peer.load(16'hffff);
    mode = 2'h2;
    uart_rx_role = 1'b1;
    uart_len = 2'h1;
    parity_mode = 2'h1;
    lsb_first = 1'b1;
    prescale_sel = 4'h0;
    divisor = 8'h1;
    wt(4);
    ur(1'b0);
    take;
    ur(1'b1);
    `CHK("parity_flag", parity_flag, 1'b1)
    take;
    flag_clear = 1'b1;
    wt(1);
    flag_clear = 1'b0;
    wt(1);
    `CHK("parity_flag", parity_flag, 1'b0)
    ur(1'b0);
    `CHK("overrun_flag", overrun_flag, 1'b0)
    ur(1'b0);
    `CHK("overrun_flag", overrun_flag, 1'b1)
    uart_rx_role = 1'b0;
    wt(3);
    seed = xs(seed);
    fork
      send({8'h0, seed[7:0]}, 32'h0);
      i_msc_peer.urx(uf);
    join
    `CHK("uart_frame", uf, {1'b1, ^seed[7:0], seed[7:0], 1'b0})
    $display("test async done");
    mode = 2'h3;
    wt(3);
    iic(1'b1, 1'b1);
    iic(1'b0, 1'b0);
    iic(1'b1, 1'b0);
    $display("test two-wire done");
    report_and_stop;
  end
endmodule
